// ### common/aie_consts.svh
`ifndef AIE_CONSTS_SVH
`define AIE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map of the software port
// ----------------------------------------------------------------------------
`define AIE_REG_CTRL     3'h0
`define AIE_REG_WREG     3'h1
`define AIE_REG_FLAGS    3'h2
`define AIE_REG_BANK     3'h3
`define AIE_REG_OPERAND  3'h4
`define AIE_REG_STATE    3'h5

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define AIE_CTRL_PSC_BIT 0
`define AIE_FLAG_C       0
`define AIE_FLAG_HALF    1
`define AIE_FLAG_Z       2
`define AIE_FLAG_RANGE   3
`define AIE_FLAG_N       4
`define AIE_CTRL_RST     8'h00
`define AIE_WREG_RST     8'h00
`define AIE_FLAGS_RST    5'h00
`define AIE_BANK_RST     4'h0
`define AIE_PC_RST       16'h0000

// ----------------------------------------------------------------------------
// Data memory addresses and timing
// ----------------------------------------------------------------------------
`define AIE_TIMER_ZERO_ADDR 12'hF10
`define AIE_PORT_ADDR       12'hF00
`define AIE_ACCESS_HI       4'hF
`define AIE_ACCESS_LO       4'h0
`define AIE_PHASES          2'h3
`define AIE_IDLE_WORD       16'h0000

`endif

// ### common/aie_pkg.sv
package aie_pkg;

  // Phase of one instruction cycle.
  typedef enum logic [1:0] {
    AIE_Q1 = 2'b00,
    AIE_Q2 = 2'b01,
    AIE_Q3 = 2'b10,
    AIE_Q4 = 2'b11
  } aie_phase_t;

endpackage

// ### core/aie_phase.sv
`timescale 1ns/1ps
`include "aie_consts.svh"

// Divides the clock into the four phases of one instruction cycle.
module aie_phase
  import aie_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  output aie_phase_t      phase_out,
  output logic            cycle_end_out
);

  // ----------------------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------------------
  // The counter wraps after the fourth phase; cycle_end marks the last phase.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_out <= AIE_Q1;
    end else begin
      phase_out <= aie_phase_t'(phase_out + 2'h1);
    end
  end

  assign cycle_end_out = (phase_out == AIE_Q4);

endmodule // aie_phase

// ### core/aie_alu.sv
`timescale 1ns/1ps
`include "aie_consts.svh"

// Eight-bit adder with the arithmetic flags of the add instructions.
module aie_alu (
  input  wire logic [7:0] acc_in,
  input  wire logic [7:0] opnd_in,
  output logic [7:0]      sum_out,
  output logic [4:0]      flags_out
);

  // ----------------------------------------------------------------------------
  // Sum and flags
  // ----------------------------------------------------------------------------
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // The half sum gives the carry out of the low nibble.
  assign full_sum = {1'b0, acc_in} + {1'b0, opnd_in};
  assign low_sum  = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]};
  assign sum_out  = full_sum[7:0];

  assign flags_out[`AIE_FLAG_C]  = full_sum[8];
  assign flags_out[`AIE_FLAG_HALF] = low_sum[4];
  assign flags_out[`AIE_FLAG_Z]  = (full_sum[7:0] == 8'h00);
  // Signed range is exceeded when both inputs agree in sign and the sum does not.
  assign flags_out[`AIE_FLAG_RANGE] = (acc_in[7] == opnd_in[7]) && (full_sum[7] != acc_in[7]);
  assign flags_out[`AIE_FLAG_N]  = full_sum[7];

endmodule // aie_alu

// ### core/aie_core.sv
`timescale 1ns/1ps
`include "aie_consts.svh"

//
// Contract
// - Port read-modify-write uses pin levels
// - Write to timer_zero clears assigned prescaler
// - Taken branch costs two cycles, second no_operation
// - Second word runs as no_operation unless consumed
// - Started table write runs until terminated
// - add_immediate adds literal to accumulator, sets flags
// - add_to_file_register adds, d picks destination
module aie_core
  import aie_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic            clk_in,
  input  wire logic            resetn_in,
  // Program memory.
  input  wire logic [15:0]     instr_in,
  output logic      [PC_W-1:0] pmem_addr_out,
  // Data memory.
  output logic      [11:0]     dmem_addr_out,
  output logic                 dmem_rd_out,
  input  wire logic [7:0]      dmem_rdata_in,
  output logic                 dmem_wr_out,
  output logic      [7:0]      dmem_wdata_out,
  // Port pins and timer.
  input  wire logic [7:0]      port_pins_in,
  output logic                 psc_clear_out,
  // Table write engine.
  output logic                 tblwr_busy_out,
  input  wire logic            tblwr_done_in,
  // Software register port.
  input  wire logic [2:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic      [7:0]      reg_rdata_out
);

  // ----------------------------------------------------------------------------
  // Phase generation and state
  // ----------------------------------------------------------------------------
  aie_phase_t      phase;
  logic            cycle_end;
  logic [15:0]     ir_q;
  logic [7:0]      wreg_q;
  logic [4:0]      flags_q;
  logic [3:0]      bank_q;
  logic [7:0]      ctrl_q;
  logic [11:0]     operand_q;
  logic            flush_q;
  logic            second_q;
  logic            tblwr_q;
  logic [7:0]      opnd_q;
  logic [7:0]      res_q;
  logic [4:0]      res_flags_q;
  logic            taken_q;
  logic [PC_W-1:0] pc_q;
  logic [11:0]     daddr_q;
  logic            psc_q;
  logic            dwr_q;
  logic            drd_q;
  logic [7:0]      rdata_q;

  aie_phase u_phase (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .phase_out     (phase),
    .cycle_end_out (cycle_end)
  );

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  // In the first phase the fetched word is decoded directly; later phases use the held copy.
  logic        in_q1;
  logic        in_q2;
  logic        in_q3;
  logic [15:0] word_fetch;
  logic [15:0] word;

  assign in_q1 = (phase == AIE_Q1);
  assign in_q2 = (phase == AIE_Q2);
  assign in_q3 = (phase == AIE_Q3);
  // A flushed slot or a consumed second word is replaced by a no_operation.
  assign word_fetch = (flush_q || second_q) ? `AIE_IDLE_WORD : instr_in;
  assign word       = in_q1 ? word_fetch : ir_q;

  logic is_addk;
  logic is_addf;
  logic is_bcond;
  logic is_bra;
  logic is_two;
  logic is_tblwr;
  logic dest_file;

  assign is_addk   = (word[15:8] == 8'h0F);
  assign is_addf   = (word[15:10] == 6'b001001);
  assign is_bcond  = (word[15:11] == 5'b11100);
  assign is_bra    = (word[15:11] == 5'b11010);
  assign is_two    = (word[15:10] == 6'b111011);
  assign is_tblwr  = (word[15:2] == 14'h0003);
  assign dest_file = word[9];

  // ----------------------------------------------------------------------------
  // Data addressing
  // ----------------------------------------------------------------------------
  // The a bit chooses bank_select addressing; otherwise the access bank splits at 0x80.
  logic [11:0] daddr;
  assign daddr = word[8] ? {bank_q, word[7:0]} :
                 (word[7] ? {`AIE_ACCESS_HI, word[7:0]} : {`AIE_ACCESS_LO, word[7:0]});

  // Port reads take the pins rather than the output latch, so a read-modify-write
  // cannot echo a stale latch value onto a pin that something else drives.
  logic       is_port;
  logic [7:0] file_val;
  assign is_port  = (daddr_q == `AIE_PORT_ADDR);
  assign file_val = is_port ? port_pins_in : dmem_rdata_in;

  // ----------------------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------------------
  logic [7:0] sum;
  logic [4:0] sum_flags;

  aie_alu u_alu (
    .acc_in    (wreg_q),
    .opnd_in   (opnd_q),
    .sum_out   (sum),
    .flags_out (sum_flags)
  );

  // ----------------------------------------------------------------------------
  // Branch condition and target
  // ----------------------------------------------------------------------------
  logic            cond_true;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] br_off;

  always_comb begin
    case (word[10:8])
      3'h0:    cond_true = flags_q[`AIE_FLAG_Z];
      3'h1:    cond_true = !flags_q[`AIE_FLAG_Z];
      3'h2:    cond_true = flags_q[`AIE_FLAG_C];
      3'h3:    cond_true = !flags_q[`AIE_FLAG_C];
      3'h4:    cond_true = flags_q[`AIE_FLAG_RANGE];
      3'h5:    cond_true = !flags_q[`AIE_FLAG_RANGE];
      3'h6:    cond_true = flags_q[`AIE_FLAG_N];
      default: cond_true = !flags_q[`AIE_FLAG_N];
    endcase
  end

  assign br_off  = is_bra ? PC_W'({{(PC_W-11){word[10]}}, word[10:0]}) :
                            PC_W'({{(PC_W-8){word[7]}}, word[7:0]});
  assign pc_next = taken_q ? PC_W'(pc_q + br_off + PC_W'(1)) : PC_W'(pc_q + PC_W'(1));

  // ----------------------------------------------------------------------------
  // Software port decode
  // ----------------------------------------------------------------------------
  logic       wr_ctrl;
  logic       wr_wreg;
  logic       wr_flags;
  logic       wr_bank;
  logic [7:0] rd_mux;

  assign wr_ctrl  = reg_wr_in && (reg_addr_in == `AIE_REG_CTRL);
  assign wr_wreg  = reg_wr_in && (reg_addr_in == `AIE_REG_WREG);
  assign wr_flags = reg_wr_in && (reg_addr_in == `AIE_REG_FLAGS);
  assign wr_bank  = reg_wr_in && (reg_addr_in == `AIE_REG_BANK);

  always_comb begin
    case (reg_addr_in)
      `AIE_REG_CTRL:    rd_mux = ctrl_q;
      `AIE_REG_WREG:    rd_mux = wreg_q;
      `AIE_REG_FLAGS:   rd_mux = {3'h0, flags_q};
      `AIE_REG_BANK:    rd_mux = {4'h0, bank_q};
      `AIE_REG_OPERAND: rd_mux = operand_q[7:0];
      `AIE_REG_STATE:   rd_mux = {5'h0, second_q, flush_q, tblwr_q};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------------------
  // Q1 decodes and issues the read, Q2 takes the operand, Q3 computes, Q4 writes.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ir_q        <= `AIE_IDLE_WORD;
      daddr_q     <= 12'h000;
      drd_q       <= 1'b0;
      opnd_q      <= 8'h00;
      res_q       <= 8'h00;
      res_flags_q <= `AIE_FLAGS_RST;
      dwr_q       <= 1'b0;
      psc_q       <= 1'b0;
      taken_q     <= 1'b0;
    end else begin
      drd_q <= 1'b0;
      dwr_q <= 1'b0;
      psc_q <= 1'b0;
      if (in_q1) begin
        ir_q    <= word_fetch;
        daddr_q <= daddr;
        drd_q   <= is_addf;
        taken_q <= is_bra || (is_bcond && cond_true);
      end
      if (in_q2) begin
        opnd_q <= is_addk ? word[7:0] : file_val;
      end
      if (in_q3) begin
        res_q       <= sum;
        res_flags_q <= sum_flags;
        dwr_q       <= is_addf && dest_file;
        // Any write to the timer count restarts its prescaler when one is assigned.
        psc_q       <= is_addf && dest_file && (daddr_q == `AIE_TIMER_ZERO_ADDR)
                       && ctrl_q[`AIE_CTRL_PSC_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Architectural state
  // ----------------------------------------------------------------------------
  // The core's own Q4 write wins over a software write in the same cycle.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wreg_q  <= `AIE_WREG_RST;
      flags_q <= `AIE_FLAGS_RST;
      bank_q  <= `AIE_BANK_RST;
      ctrl_q  <= `AIE_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_in;
      end
      if (wr_bank) begin
        bank_q <= reg_wdata_in[3:0];
      end
      if (cycle_end && (is_addk || is_addf)) begin
        flags_q <= res_flags_q;
      end else if (wr_flags) begin
        flags_q <= reg_wdata_in[4:0];
      end
      if (cycle_end && (is_addk || (is_addf && !dest_file))) begin
        wreg_q <= res_q;
      end else if (wr_wreg) begin
        wreg_q <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Program flow
  // ----------------------------------------------------------------------------
  // A taken branch loads the target and forces the next slot to a no_operation.
  // The model does not prefetch, so the flushed slot is an explicit idle cycle.
  // That slot holds the counter; advancing it would skip the branch target.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pc_q      <= `AIE_PC_RST;
      flush_q   <= 1'b0;
      second_q  <= 1'b0;
      operand_q <= 12'h000;
    end else if (cycle_end) begin
      pc_q    <= flush_q ? pc_q : pc_next;
      flush_q <= taken_q;
      // The word after a two-word opener is kept as its operand, never executed.
      second_q <= is_two && !second_q;
      if (second_q) begin
        operand_q <= instr_in[11:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Table write engine
  // ----------------------------------------------------------------------------
  // Once started the write holds busy until memory reports completion, whatever
  // the instruction stream does meanwhile; a repeated start cannot cut it short.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tblwr_q <= 1'b0;
    end else if (in_q3 && is_tblwr) begin
      tblwr_q <= 1'b1;
    end else if (tblwr_done_in) begin
      tblwr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign pmem_addr_out  = pc_q;
  assign dmem_addr_out  = daddr_q;
  assign dmem_rd_out    = drd_q;
  assign dmem_wr_out    = dwr_q;
  assign dmem_wdata_out = res_q;
  assign psc_clear_out  = psc_q;
  assign tblwr_busy_out = tblwr_q;
  assign reg_rdata_out  = rdata_q;

endmodule // aie_core

// ### dv/aie_core_monitor.sv
`timescale 1ns/1ps
`include "aie_consts.svh"
// ----------------------------------------------------------------------------
// Port checker of the execution core
// ----------------------------------------------------------------------------
module aie_core_monitor #(
  parameter int PC_W = 16
) (
  input wire logic            clk_in,
  input wire logic            resetn_in,
  input wire logic [PC_W-1:0] pmem_addr_out,
  input wire logic [11:0]     dmem_addr_out,
  input wire logic            dmem_rd_out,
  input wire logic            dmem_wr_out,
  input wire logic            psc_clear_out,
  input wire logic            tblwr_busy_out,
  input wire logic            tblwr_done_in
);
  logic [1:0] ph_q;
  // The first edge after reset is a Q1 edge, so a free count tracks the phase.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // A register add reads in Q2 and writes back in Q4 of the same cycle.
  sequence s_read_write;
    dmem_rd_out ##2 dmem_wr_out;
  endsequence
  rd_in_q2_a: assert property (dmem_rd_out |-> ph_q == 2'h1)
    else $error("data read outside the read phase");
  wr_in_q4_a: assert property (dmem_wr_out |-> ph_q == 2'h3)
    else $error("data write outside the write phase");
  rd_one_clock_a: assert property (dmem_rd_out |=> !dmem_rd_out)
    else $error("data read strobe longer than one clock");
  psc_on_timer_a: assert property (psc_clear_out |-> dmem_wr_out && dmem_addr_out == `AIE_TIMER_ZERO_ADDR)
    else $error("prescaler clear without a timer write");
  pc_q4_only_a: assert property (ph_q != 2'h3 |=> $stable(pmem_addr_out))
    else $error("program address moved outside Q4");
  addr_kept_a: assert property (s_read_write |-> dmem_addr_out == $past(dmem_addr_out, 2))
    else $error("write address differs from read address");
  tbl_holds_a: assert property (tblwr_busy_out && !tblwr_done_in |=> tblwr_busy_out)
    else $error("table write ended before it was terminated");
  tbl_starts_q3_a: assert property ($rose(tblwr_busy_out) |-> ph_q == 2'h3)
    else $error("table write started outside Q3");
endmodule // aie_core_monitor

bind aie_core aie_core_monitor #(.PC_W(PC_W)) i_mon (.clk_in, .resetn_in, .pmem_addr_out, .dmem_addr_out,
  .dmem_rd_out, .dmem_wr_out, .psc_clear_out, .tblwr_busy_out, .tblwr_done_in);

// ### dv/aie_pmem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Program memory that answers at once with the word the bench placed
// ----------------------------------------------------------------------------
module aie_pmem_model (
  input  wire logic [15:0] addr_in,
  output logic      [15:0] word_out
);
  logic [15:0] mem [256];
  // Unused places hold an all-ones word, which must itself run as no_operation.
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  assign word_out = mem[addr_in[7:0]];
endmodule // aie_pmem_model

// ### dv/add_instruction_execution_tb_top.sv
`timescale 1ns/1ps
`include "aie_consts.svh"
// ----------------------------------------------------------------------------
// Random instruction stream checked against a reference model
// ----------------------------------------------------------------------------
module add_instruction_execution_tb_top;
  logic        clk_in = 1'b0, resetn_in = 1'b0, dmem_rd_out, dmem_wr_out, psc_clear_out, tblwr_busy_out;
  logic        tblwr_done_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, idle, two, busy, dnow, tk, pv;
  logic [2:0]  reg_addr_in = 3'h0;
  logic [7:0]  dmem_rdata_in, dmem_wdata_out, reg_rdata_out, w, fl, bank, ctrl, k, f, sum, wd, pv_s, opd, opn;
  logic [7:0]  port_pins_in = 8'h00, reg_wdata_in = 8'h00, dm [4096];
  logic [11:0] dmem_addr_out, ea, pv_a;
  logic [15:0] instr_in, pmem_addr_out, pc, op;
  logic [31:0] rs = 32'd97, r;
  logic [8:0]  s9;
  logic [3:0]  fv;
  int          err_total = 0, compares = 0, psc_n = 0, psc_e = 0, cyc = 0;

  aie_core i_dut (.clk_in, .resetn_in, .instr_in, .pmem_addr_out, .dmem_addr_out, .dmem_rd_out,
    .dmem_rdata_in, .dmem_wr_out, .dmem_wdata_out, .port_pins_in, .psc_clear_out, .tblwr_busy_out,
    .tblwr_done_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
  aie_pmem_model i_pmem (.addr_in(pmem_addr_out), .word_out(instr_in));

  always #20 clk_in = ~clk_in;
  // Data memory; a line not being read shows the inverted cell so stale data cannot pass.
  assign dmem_rdata_in = dmem_rd_out ? dm[dmem_addr_out] : ~dm[dmem_addr_out];
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (dmem_wr_out === 1'b1) dm[dmem_addr_out] <= dmem_wdata_out;
    if (psc_clear_out === 1'b1) psc_n <= psc_n + 1;
    if (cyc == 2000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask
  task automatic wrap_up();
    $display("compares=%0d mismatches=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reference add: sum and all five arithmetic flags.
  task automatic add(input logic [7:0] o);
    s9 = {1'b0, w} + {1'b0, o};
    sum = s9[7:0];
    fl = 8'h00;
    fl[`AIE_FLAG_C] = s9[8];
    fl[`AIE_FLAG_HALF] = (5'(w[3:0]) + 5'(o[3:0])) > 5'h0F;
    fl[`AIE_FLAG_Z] = (sum == 8'h00);
    fl[`AIE_FLAG_RANGE] = (w[7] == o[7]) && (sum[7] != w[7]);
    fl[`AIE_FLAG_N] = sum[7];
  endtask

  initial begin
    foreach (dm[i]) begin
      r = xs();
      dm[i] = r[7:0];
    end
    {w, fl, bank, ctrl, pc, idle, two, busy, pv, opd, opn} = '0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    reg_rd_in <= 1'b1;
    // Reset values of indices 0 to 6, unmapped 6 included, read back to back.
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_in);
      reg_addr_in <= 3'(i + 1);
      if (i == 6) reg_rd_in <= 1'b0;
      @(negedge clk_in);
      chk8(reg_rdata_out, 8'h00);
    end
    $display("test reset_values done");
    pc = 16'h0002;
    repeat (300) begin
      @(posedge clk_in);
      r = xs();
      k = r[15] ? r[23:16] : {8{r[14]}};
      f = r[13] ? r[23:16] : {3'h0, r[14], 4'h0};
      wd = r[16] ? 8'hFF : r[23:16];
      dnow = busy & r[12];
      case (r[30:28])
        3'd0, 3'd1: op = {8'h0F, k};
        3'd2, 3'd3: op = {6'b001001, r[27:26], f};
        3'd4: op = {5'b11010, r[10:0]};
        3'd5: op = {5'b11100, r[10:0]};
        3'd6: op = {6'b111011, r[9:0]};
        default: op = r[27] ? {14'h0003, r[1:0]} : {4'hF, r[11:0]};
      endcase
      if (!idle) i_pmem.mem[pc[7:0]] <= op;
      if (!idle && r[30:28] == 3'd6) i_pmem.mem[8'(pc + 16'h1)] <= {8'h0F, k};
      port_pins_in <= r[31:24];
      tblwr_done_in <= dnow;
      reg_wr_in <= r[25];
      reg_addr_in <= r[24] ? 3'h3 : 3'h0;
      reg_wdata_in <= wd;
      @(posedge clk_in);
      {reg_wr_in, tblwr_done_in, reg_rd_in} <= 3'b001;
      reg_addr_in <= 3'h1;
      @(negedge clk_in);
      chk16(pmem_addr_out, pc);
      if (pv) chk8(dm[pv_a], pv_s);
      chk8(8'(psc_n), 8'(psc_e));
      @(posedge clk_in);
      reg_addr_in <= 3'h2;
      @(negedge clk_in);
      chk8(reg_rdata_out, w);
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_in);
      chk8(reg_rdata_out, fl);
      // Reference execution of the instruction now in flight.
      if (r[25] && !r[24]) ctrl = wd;
      fv = {fl[`AIE_FLAG_N], fl[`AIE_FLAG_RANGE], fl[`AIE_FLAG_C], fl[`AIE_FLAG_Z]};
      busy = busy & !dnow;
      {tk, pv} = 2'b00;
      ea = r[26] ? {bank[3:0], f} : {{4{f[7]}}, f};
      if (idle) begin
        if (two) {pc, opd} = {pc + 16'h1, opn};
        two = 1'b0;
      end else begin
        pc = pc + 16'h1;
        case (r[30:28])
          3'd0, 3'd1: begin
            add(k);
            w = sum;
          end
          3'd2, 3'd3: begin
            add(ea == `AIE_PORT_ADDR ? r[31:24] : dm[ea]);
            if (r[27]) begin
              {pv, pv_a, pv_s} = {1'b1, ea, sum};
              if (ea == `AIE_TIMER_ZERO_ADDR && ctrl[0]) psc_e++;
            end else begin
              w = sum;
            end
          end
          3'd4: {tk, pc} = {1'b1, pc + {{5{op[10]}}, op[10:0]}};
          3'd5: begin
            tk = fv[op[10:9]] ^ op[8];
            if (tk) pc = pc + {{8{op[7]}}, op[7:0]};
          end
          3'd6: {two, opn} = {1'b1, k};
          default: busy = busy | r[27];
        endcase
      end
      chk8({7'h00, tblwr_busy_out}, {7'h00, busy});
      idle = tk | two;
      if (r[25] && r[24]) bank = wd;
    end
    // The operand of the last two-word pair that ran lands at the coming Q4 edge, so read after it.
    @(posedge clk_in);
    {reg_rd_in, reg_addr_in} <= {1'b1, 3'h4};
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk8(reg_rdata_out, opd);
    $display("test random_program done");
    wrap_up();
  end
endmodule // add_instruction_execution_tb_top
